// *** buzzer_ir_pkg.sv ***
package buzzer_ir_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned RC_FAST_HZ  = 4_000_000;
  localparam int unsigned RC_TICK_DIV = CLK_HZ / RC_FAST_HZ;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_TIMER_LOW    = 5'h00;
  localparam logic [4:0] ADDR_TIMER_CTRL   = 5'h01;
  localparam logic [4:0] ADDR_BUZZER_CTRL  = 5'h05;
  localparam logic [4:0] ADDR_CARRIER_CTRL = 5'h06;
  localparam logic [4:0] ADDR_TIMER_HIGH   = 5'h09;
  localparam logic [4:0] ADDR_PWM_B_CTRL   = 5'h0A;
  localparam logic [4:0] ADDR_PWM_B_DUTY   = 5'h0C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned TONE_EN_BIT   = 7;
  localparam int unsigned CARR_EN_BIT   = 0;
  localparam int unsigned CARR_RATE_BIT = 1;
  localparam int unsigned CARR_POL_BIT  = 2;
  localparam int unsigned CARR_XTAL_BIT = 7;
  localparam int unsigned PWM_OE_BIT    = 7;
  localparam int unsigned PWM_AL_BIT    = 6;
  localparam int unsigned TIMER_EN_BIT  = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] FSEL_RESET       = 4'hF;
  localparam logic [7:0] TIMER_HIGH_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET       = 8'h00;
  localparam logic [7:0] RELOAD_RESET     = 8'h00;
  localparam logic [9:0] COUNT_RESET      = 10'h000;

  // ----------------------------------------------------------------
  // carrier division ratios
  // ----------------------------------------------------------------
  localparam logic [6:0] DIV_FAST_57K = 7'h40;
  localparam logic [6:0] DIV_FAST_38K = 7'h60;
  localparam logic [6:0] DIV_SLOW_57K = 7'h08;
  localparam logic [6:0] DIV_SLOW_38K = 7'h0C;

endpackage

// *** carrier_link_if.sv ***
interface carrier_link_if;
  logic enable;
  logic rate_57k;
  logic crystal_358;
  logic use_internal_rc;
  logic xtal_tick;
  logic carrier;

  modport ctrl (
    output enable, rate_57k, crystal_358, use_internal_rc, xtal_tick,
    input  carrier
  );
  modport gen (
    input  enable, rate_57k, crystal_358, use_internal_rc, xtal_tick,
    output carrier
  );
endinterface

// *** carrier_divider.sv ***
module carrier_divider
  import buzzer_ir_pkg::*;
(
  input  logic           clk,
  input  logic           rst_n,
  carrier_link_if.gen    link
);

  logic [2:0] rc_count;
  logic       rc_tick;
  logic       src_tick;
  logic [6:0] ratio;
  logic [6:0] half;
  logic [6:0] div_count;
  logic       carrier;

  // ----------------------------------------------------------------
  // fixed 4 MHz reference, independent of the system clock choice
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_count <= 3'h0;
      rc_tick  <= 1'b0;
    end else if (rc_count == 3'(RC_TICK_DIV - 1)) begin
      rc_count <= 3'h0;
      rc_tick  <= 1'b1;
    end else begin
      rc_count <= rc_count + 3'h1;
      rc_tick  <= 1'b0;
    end
  end

  // only the fast oscillator feeds the divider
  assign src_tick = link.use_internal_rc ? rc_tick : link.xtal_tick;

  always_comb begin
    // crystal kind is a don't-care on the internal oscillator
    if (link.use_internal_rc || link.crystal_358) begin
      ratio = link.rate_57k ? DIV_FAST_57K : DIV_FAST_38K;
    end else begin
      ratio = link.rate_57k ? DIV_SLOW_57K : DIV_SLOW_38K;
    end
    half = ratio >> 1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 7'h00;
      carrier   <= 1'b0;
    end else if (!link.enable) begin
      div_count <= 7'h00;
      carrier   <= 1'b0;
    end else if (src_tick) begin
      // >= so a rate change mid-count cannot overrun
      if (div_count >= half - 7'h01) begin
        div_count <= 7'h00;
        carrier   <= ~carrier;
      end else begin
        div_count <= div_count + 7'h01;
      end
    end
  end

  assign link.carrier = carrier;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_carrier_idle;
    !link.enable |=> !carrier;
  endproperty
  a_carrier_idle: assert property (p_carrier_idle)
    else $error("carrier running while disabled");

  property p_rc_tick;
    rc_tick |=> !rc_tick [*4] ##1 rc_tick;
  endproperty
  a_rc_tick: assert property (p_rc_tick)
    else $error("internal reference not 4 MHz");

  property p_src_only;
    link.enable && !src_tick |=> $stable(carrier);
  endproperty
  a_src_only: assert property (p_src_only)
    else $error("carrier moved without a fast oscillator tick");

  c_carrier_toggle: cover property (link.enable ##1 $rose(carrier));
endmodule

// *** buzzer_ir_pwm.sv ***
// Functional notes
// - buzzer select 0-7 gives prescaler output divided by 2 to 256
// - buzzer select 8-15 follows timer count bit 0 to bit 7
// - tone appears only while tone enable is set
// - carrier output only while carrier enable bit 0 is set
// - rate select 1 gives 57 kHz, 0 gives 38 kHz
// - polarity 0 emits on pin data 1, polarity 1 on data 0
// - crystal kind 1 means 3.58 MHz crystal, 0 means 455 kHz
// - crystal kind is ignored on the internal fast oscillator
// - carrier clocked only from the fast oscillator
// - divide by 64 or 96 on fast sources, 8 or 12 on 455 kHz
// - internal oscillator mode feeds a fixed 4 MHz to the carrier
// - pwm active-low select inverts the output, resets to 0
// - pwm output enable routes wave to one of two pins, else GPIO
// - pwm duty is timer high bits [3:2] over duty low byte
// - pwm frame is reload value timer high bits [5:4] over low byte
// - timer is a 10-bit down counter, low byte read live, write loads
module buzzer_ir_pwm
  import buzzer_ir_pkg::*;
(
  input  logic       clk,
  input  logic       rst_n,
  input  logic [4:0] addr,
  input  logic [7:0] wdata,
  input  logic       wr,
  input  logic       rd,
  output logic [7:0] rdata,
  input  logic       instr_tick,
  input  logic       fast_osc_tick,
  input  logic       internal_rc_mode,
  input  logic       carrier_pin_data,
  input  logic       pwm_b_pin_select,
  output logic       tone_out,
  output logic       carrier_out,
  output logic       pwm_b_wave,
  output logic       port_b_pin_two_pwm_en,
  output logic       port_a_pin_zero_pwm_en
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic       tone_output_enable;
  logic [3:0] buzzer_freq_select;
  logic       carrier_enable;
  logic       carrier_rate_select;
  logic       carrier_polarity_select;
  logic       crystal_kind_select;
  logic       pwm_b_active_low;
  logic       pwm_b_output_enable;
  logic [7:0] pwm_b_duty_low;
  logic [7:0] timer_high_bits;
  logic [7:0] timer_a_low_byte;
  logic       timer_enable;
  logic [9:0] timer_count;
  logic [7:0] prescale_count;

  logic [9:0] reload_value;
  logic [9:0] pwm_b_duty;
  logic       next_tone;
  logic       pwm_b_active;
  logic [7:0] next_rdata;
  logic       timer_bit0;

  carrier_link_if link ();

  function automatic logic hit(
    input logic [4:0] a,
    input logic [4:0] offset
  );
    hit = (a == offset);
  endfunction

  // ----------------------------------------------------------------
  // buzzer control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_output_enable <= 1'b0;
      buzzer_freq_select <= FSEL_RESET;
    end else if (wr && hit(addr, ADDR_BUZZER_CTRL)) begin
      tone_output_enable <= wdata[TONE_EN_BIT];
      buzzer_freq_select <= wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // carrier control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_enable          <= 1'b0;
      carrier_rate_select     <= 1'b0;
      carrier_polarity_select <= 1'b0;
      crystal_kind_select     <= 1'b0;
    end else if (wr && hit(addr, ADDR_CARRIER_CTRL)) begin
      carrier_enable          <= wdata[CARR_EN_BIT];
      carrier_rate_select     <= wdata[CARR_RATE_BIT];
      carrier_polarity_select <= wdata[CARR_POL_BIT];
      crystal_kind_select     <= wdata[CARR_XTAL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // pwm control and duty
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_b_active_low    <= 1'b0;
      pwm_b_output_enable <= 1'b0;
    end else if (wr && hit(addr, ADDR_PWM_B_CTRL)) begin
      pwm_b_active_low    <= wdata[PWM_AL_BIT];
      pwm_b_output_enable <= wdata[PWM_OE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_b_duty_low <= DUTY_RESET;
    end else if (wr && hit(addr, ADDR_PWM_B_DUTY)) begin
      pwm_b_duty_low <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_high_bits <= TIMER_HIGH_RESET;
    end else if (wr && hit(addr, ADDR_TIMER_HIGH)) begin
      timer_high_bits <= wdata;
    end
  end

  assign pwm_b_duty   = {timer_high_bits[3:2], pwm_b_duty_low};
  assign reload_value = {timer_high_bits[5:4], timer_a_low_byte};

  // ----------------------------------------------------------------
  // timer and prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_enable <= 1'b0;
    end else if (wr && hit(addr, ADDR_TIMER_CTRL)) begin
      timer_enable <= wdata[TIMER_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_a_low_byte <= RELOAD_RESET;
    end else if (wr && hit(addr, ADDR_TIMER_LOW)) begin
      timer_a_low_byte <= wdata;
    end
  end

  // a write wins over a count tick in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= COUNT_RESET;
    end else if (wr && hit(addr, ADDR_TIMER_LOW)) begin
      timer_count <= {timer_high_bits[5:4], wdata};
    end else if (timer_enable && instr_tick) begin
      if (timer_count == 10'h000) begin
        timer_count <= reload_value;
      end else begin
        timer_count <= timer_count - 10'h001;
      end
    end
  end

  // free running so the tone is available with the timer stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_count <= 8'h00;
    end else if (instr_tick) begin
      prescale_count <= prescale_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // waveform selection
  // ----------------------------------------------------------------
  always_comb begin
    if (buzzer_freq_select[3]) begin
      next_tone = timer_count[buzzer_freq_select[2:0]];
    end else begin
      next_tone = prescale_count[buzzer_freq_select[2:0]];
    end
  end

  assign pwm_b_active = (timer_count <= pwm_b_duty);
  assign timer_bit0   = timer_count[0];

  assign link.enable          = carrier_enable;
  assign link.rate_57k        = carrier_rate_select;
  assign link.crystal_358     = crystal_kind_select;
  assign link.use_internal_rc = internal_rc_mode;
  assign link.xtal_tick       = fast_osc_tick;

  carrier_divider u_carrier (
    .clk   (clk),
    .rst_n (rst_n),
    .link  (link.gen)
  );

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_out <= 1'b0;
    end else begin
      tone_out <= tone_output_enable & next_tone;
    end
  end

  // pin data gates the carrier, polarity picks the sense
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_out <= 1'b0;
    end else begin
      carrier_out <= carrier_enable & link.carrier
                   & (carrier_pin_data ^ carrier_polarity_select);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_b_wave <= 1'b0;
    end else begin
      pwm_b_wave <= pwm_b_active ^ pwm_b_active_low;
    end
  end

  // only one pin is claimed at a time; the other stays GPIO
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_pin_two_pwm_en  <= 1'b0;
      port_a_pin_zero_pwm_en <= 1'b0;
    end else begin
      port_b_pin_two_pwm_en  <= pwm_b_output_enable & ~pwm_b_pin_select;
      port_a_pin_zero_pwm_en <= pwm_b_output_enable & pwm_b_pin_select;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (hit(addr, ADDR_TIMER_LOW)) begin
      next_rdata = timer_count[7:0];
    end else if (hit(addr, ADDR_TIMER_CTRL)) begin
      next_rdata = {7'h00, timer_enable};
    end else if (hit(addr, ADDR_TIMER_HIGH)) begin
      next_rdata = {2'h0, timer_high_bits[5:2], 2'h0};
    end else if (hit(addr, ADDR_PWM_B_CTRL)) begin
      next_rdata = {pwm_b_output_enable, pwm_b_active_low, 6'h00};
    end
  end

  // data stands for exactly one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_tone_off;
    !tone_output_enable |=> !tone_out;
  endproperty
  a_tone_off: assert property (p_tone_off)
    else $error("tone present while disabled");

  property p_tone_prescale;
    tone_output_enable && buzzer_freq_select == 4'h0 && instr_tick
      ##1 tone_output_enable && buzzer_freq_select == 4'h0
      |=> $changed(tone_out);
  endproperty
  a_tone_prescale: assert property (p_tone_prescale)
    else $error("divide-by-2 tone did not toggle");

  property p_tone_timer;
    tone_output_enable && buzzer_freq_select == 4'h8
      |=> tone_out == $past(timer_bit0);
  endproperty
  a_tone_timer: assert property (p_tone_timer)
    else $error("tone not following timer bit 0");

  property p_carrier_off;
    !carrier_enable |=> !carrier_out;
  endproperty
  a_carrier_off: assert property (p_carrier_off)
    else $error("carrier out while disabled");

  property p_carrier_pol;
    carrier_pin_data == carrier_polarity_select |=> !carrier_out;
  endproperty
  a_carrier_pol: assert property (p_carrier_pol)
    else $error("carrier emitted on wrong pin level");

  property p_pwm_high;
    !pwm_b_active_low && timer_count <= pwm_b_duty |=> pwm_b_wave;
  endproperty
  a_pwm_high: assert property (p_pwm_high)
    else $error("pwm not active at or below duty");

  property p_pwm_low;
    pwm_b_active_low && timer_count <= pwm_b_duty |=> !pwm_b_wave;
  endproperty
  a_pwm_low: assert property (p_pwm_low)
    else $error("active-low pwm not inverted");

  property p_route;
    !pwm_b_output_enable
      |=> !port_b_pin_two_pwm_en && !port_a_pin_zero_pwm_en;
  endproperty
  a_route: assert property (p_route)
    else $error("pwm claims a pin while disabled");

  property p_timer_load;
    wr && addr == ADDR_TIMER_LOW |=> timer_count[7:0] == $past(wdata);
  endproperty
  a_timer_load: assert property (p_timer_load)
    else $error("timer write did not load counter");

  property p_timer_wrap;
    timer_enable && instr_tick && timer_count == 10'h000 && !wr
      |=> timer_count == reload_value;
  endproperty
  a_timer_wrap: assert property (p_timer_wrap)
    else $error("timer did not reload at underflow");

  property p_wo_read;
    rd && addr == ADDR_CARRIER_CTRL |=> rdata == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only register read nonzero");

  c_tone_on: cover property (tone_output_enable ##1 $rose(tone_out));
  c_carrier: cover property ($rose(carrier_out));
  c_pwm_pin: cover property ($rose(port_a_pin_zero_pwm_en));
  c_wrap: cover property (timer_enable && timer_count == 10'h000
                          && instr_tick);
endmodule

// *** buzzer_ir_pwm_tb_top.sv ***
module buzzer_ir_pwm_tb_top;
  import buzzer_ir_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // stimulus and design
  // ------------------------------------------------------------
  typedef struct packed {
    logic [4:0] a;
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] e;
  } row_type;

  typedef struct packed {
    logic       mode;
    logic [7:0] ctrl;
    logic [9:0] per;
  } carr_type;

  logic       clk              = 1'b0;
  logic       rst_n            = 1'b0;
  logic [4:0] addr             = 5'h00;
  logic [7:0] wdata            = 8'h00;
  logic       wr               = 1'b0;
  logic       rd               = 1'b0;
  logic [7:0] rdata;
  logic       instr_tick       = 1'b0;
  logic       fast_osc_tick    = 1'b0;
  logic       internal_rc_mode = 1'b1;
  logic       carrier_pin_data = 1'b1;
  logic       pwm_b_pin_select = 1'b0;
  logic       tone_out;
  logic       carrier_out;
  logic       pwm_b_wave;
  logic       pin_b_en;
  logic       pin_a_en;
  logic [1:0] osc_cnt          = 2'h0;
  int         errors           = 0;
  int         compares         = 0;
  int         cycles           = 0;

  // writes and unmapped/write-only reads
  row_type rows [8] = '{
    '{5'h0A, 8'hC0, 8'hC0, 8'hC0}, '{5'h0A, 8'h40, 8'hC0, 8'h40},
    '{5'h09, 8'h3C, 8'h3C, 8'h3C}, '{5'h05, 8'h8F, 8'hFF, 8'h00},
    '{5'h06, 8'h87, 8'hFF, 8'h00}, '{5'h0C, 8'h5A, 8'hFF, 8'h00},
    '{5'h1F, 8'hFF, 8'hFF, 8'h00}, '{5'h0A, 8'h00, 8'hC0, 8'h00}};

  // internal rc: clk/5 source; crystal: one tick per 4 clocks
  carr_type carr [7] = '{
    '{1'b1, 8'h03, 10'd320}, '{1'b1, 8'h01, 10'd480},
    '{1'b1, 8'h83, 10'd320}, '{1'b0, 8'h83, 10'd256},
    '{1'b0, 8'h81, 10'd384}, '{1'b0, 8'h03, 10'd32},
    '{1'b0, 8'h01, 10'd48}};

  always #25 clk = ~clk;

  // free-running crystal ticks, ignored in rc mode
  always @(posedge clk) begin
    osc_cnt       <= osc_cnt + 2'h1;
    fast_osc_tick <= (osc_cnt == 2'h3);
  end

  buzzer_ir_pwm dut_u (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr                     (wr),
    .rd                     (rd),
    .rdata                  (rdata),
    .instr_tick             (instr_tick),
    .fast_osc_tick          (fast_osc_tick),
    .internal_rc_mode       (internal_rc_mode),
    .carrier_pin_data       (carrier_pin_data),
    .pwm_b_pin_select       (pwm_b_pin_select),
    .tone_out               (tone_out),
    .carrier_out            (carrier_out),
    .pwm_b_wave             (pwm_b_wave),
    .port_b_pin_two_pwm_en  (pin_b_en),
    .port_a_pin_zero_pwm_en (pin_a_en)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // rdata stands only in the cycle after the strobe edge
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // outputs lag their cause by one register stage
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic tick;
    @(posedge clk);
    instr_tick <= 1'b1;
    @(posedge clk);
    instr_tick <= 1'b0;
    settle();
  endtask

  // cycles between two rising edges; 0 if fewer than two seen
  task automatic period(output int p);
    int   n;
    int   edges;
    logic last;
    n     = 0;
    edges = 0;
    p     = 0;
    last  = carrier_out;
    while (edges < 2 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
      p++;
      if (carrier_out && !last) begin
        edges++;
        if (edges == 1) p = 0;
      end
      last = carrier_out;
    end
    if (edges < 2) p = 0;
  endtask

  task automatic quiet(output int ones);
    ones = 0;
    repeat (600) begin
      @(posedge clk);
      #1;
      if (carrier_out !== 1'b0) ones++;
    end
  endtask

  // ------------------------------------------------------------
  // timeout
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [9:0] c;
    int         p;
    int         tg;
    logic       last;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check({tone_out, carrier_out, pin_b_en, pin_a_en}, 4'h0);
    // count 0 already sits at duty 0, so the wave starts out active
    check(pwm_b_wave, 1'b1);
    rd_reg(ADDR_PWM_B_CTRL, d);
    check(d & 8'hC0, 0);
    done("reset");

    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, d);
      check(d & rows[i].m, rows[i].e);
    end
    done("registers");

    wr_reg(ADDR_PWM_B_CTRL, 8'h80);
    settle();
    check({pin_b_en, pin_a_en}, 2'b10);
    @(posedge clk);
    pwm_b_pin_select <= 1'b1;
    settle();
    check({pin_b_en, pin_a_en}, 2'b01);
    wr_reg(ADDR_PWM_B_CTRL, 8'h00);
    settle();
    check({pin_b_en, pin_a_en}, 2'b00);
    done("pin routing");

    // frame 4..0, duty 2
    wr_reg(ADDR_TIMER_HIGH, 8'h00);
    wr_reg(ADDR_PWM_B_DUTY, 8'h02);
    wr_reg(ADDR_TIMER_LOW, 8'h04);
    wr_reg(ADDR_TIMER_CTRL, 8'h01);
    wr_reg(ADDR_PWM_B_CTRL, 8'h80);
    settle();
    c = 10'h004;
    check(pwm_b_wave, 0);
    repeat (7) begin
      tick();
      c = (c == 10'h000) ? 10'h004 : c - 10'h001;
      check(pwm_b_wave, c <= 10'h002);
      rd_reg(ADDR_TIMER_LOW, d);
      check(d, c);
    end
    wr_reg(ADDR_PWM_B_CTRL, 8'hC0);
    settle();
    check(pwm_b_wave, !(c <= 10'h002));
    // duty low 1 alone sits below the count of 2; the high bits lift it
    wr_reg(ADDR_PWM_B_DUTY, 8'h01);
    settle();
    check(pwm_b_wave, 1'b1);
    wr_reg(ADDR_TIMER_HIGH, 8'h0C);
    settle();
    check(pwm_b_wave, 0);
    wr_reg(ADDR_PWM_B_CTRL, 8'h00);
    done("pwm");

    wr_reg(ADDR_TIMER_CTRL, 8'h00);
    wr_reg(ADDR_TIMER_HIGH, 8'h00);
    wr_reg(ADDR_TIMER_LOW, 8'hA5);
    for (int s = 8; s < 16; s++) begin
      wr_reg(ADDR_BUZZER_CTRL, 8'h80 | 8'(s));
      settle();
      check(tone_out, 8'hA5 >> (s - 8) & 8'h01);
    end
    wr_reg(ADDR_BUZZER_CTRL, 8'h08);
    settle();
    check(tone_out, 0);
    // bit n of the prescaler changes twice in 2^(n+1) ticks
    for (int s = 0; s < 8; s++) begin
      wr_reg(ADDR_BUZZER_CTRL, 8'h80 | 8'(s));
      settle();
      last = tone_out;
      tg   = 0;
      repeat (2 << s) begin
        tick();
        if (tone_out !== last) tg++;
        last = tone_out;
      end
      check(10'(tg), 2);
    end
    wr_reg(ADDR_BUZZER_CTRL, 8'h00);
    done("buzzer");

    foreach (carr[i]) begin
      @(posedge clk);
      internal_rc_mode <= carr[i].mode;
      wr_reg(ADDR_CARRIER_CTRL, carr[i].ctrl);
      period(p);
      period(p);
      check(10'(p), carr[i].per);
    end
    @(posedge clk);
    internal_rc_mode <= 1'b1;
    wr_reg(ADDR_CARRIER_CTRL, 8'h05);
    quiet(tg);
    check(10'(tg), 0);
    @(posedge clk);
    carrier_pin_data <= 1'b0;
    period(p);
    period(p);
    check(10'(p), 10'd480);
    wr_reg(ADDR_CARRIER_CTRL, 8'h04);
    settle();
    quiet(tg);
    check(10'(tg), 0);
    done("carrier");
    end_of_test();
  end
endmodule
